/* File: pkg/svd_pkg.sv */
/*
  Shared constants for the supply voltage event detector.
  Assumes a single 125 MHz clock and an 8-bit register port.
*/
package svd_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_REQ2 = 4'h1;
  localparam logic [3:0] ADDR_IRQ_EN2 = 4'h2;
  localparam logic [3:0] ADDR_IRQ_PRI2 = 4'h3;
  localparam logic [3:0] ADDR_INT_CTRL = 4'h4;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_DIR = 7;
  localparam int BIT_STABLE = 5;
  localparam int BIT_EN = 4;
  localparam int BIT_EVENT = 2;
  localparam int BIT_GIE = 7;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;
  localparam logic [3:0] LEVEL_RESET = 4'h5;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ = 125;
  localparam int STARTUP_US = 20;
  localparam int STARTUP_CYCLES = STARTUP_US * CLOCK_MHZ;
  localparam int CNT_W = 16;
  localparam int SYNC_STAGES = 2;
endpackage

/* File: design/svd_sync.sv */
/*
  Two flip-flop level synchroniser, one per bit.
  Assumes inputs are levels, held for at least two clocks.
*/
module svd_sync
  import svd_pkg::*;
#(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule // svd_sync

/* File: design/svd_detector.sv */
/*
  Control and event logic of the supply voltage event detector.
  Assumes an analog comparator and reference outside, giving asynchronous
  levels, and a register master on the plain strobe port.
*/
// Local design decisions: the register addresses and the plain strobed port.
module svd_detector
  import svd_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Analog side
  input wire logic comp_above,
  input wire logic ref_ready,
  input wire logic external_trip_input,
  output logic analog_power_en,
  output logic [3:0] tap_select,
  output logic external_select,
  output logic trip_direction_out,
  // System side
  input wire logic in_sleep,
  output logic irq_request,
  output logic irq_priority,
  output logic wake_request
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic trip_direction_select_r;
  logic detector_enable_r;
  logic [3:0] trip_level_select_r;
  logic voltage_event_flag_r;
  logic voltage_event_irq_enable_r;
  logic voltage_event_priority_r;
  logic global_irq_enable_r;
  logic reference_stable_flag_r;
  logic [CNT_W-1:0] settle_cnt_r;
  logic [7:0] reg_rdata_r;
  logic [1:0] sync_out;
  logic comp_s;
  logic ready_s;
  logic trip_now;
  logic trip_edge;
  logic event_set;
  logic ctrl_wr;
  logic flag_clear;
  logic wake_r;

  assign ctrl_wr = reg_write && (reg_addr == ADDR_CONTROL);

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  svd_sync #(.W(SYNC_STAGES)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .din({comp_above, ref_ready}),
    .dout(sync_out)
  );
  assign comp_s = sync_out[1];
  assign ready_s = sync_out[0];

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      trip_direction_select_r <= 1'b0;
      detector_enable_r <= 1'b0;
      trip_level_select_r <= LEVEL_RESET;
    end else if (ctrl_wr) begin
      trip_direction_select_r <= reg_wdata[BIT_DIR];
      detector_enable_r <= reg_wdata[BIT_EN];
      trip_level_select_r <= reg_wdata[3:0];
    end
  end

  // Analog controls follow the register; power drops with enable
  assign analog_power_en = detector_enable_r;
  assign external_select = (trip_level_select_r == LEVEL_EXTERNAL);
  assign tap_select = trip_level_select_r;
  assign trip_direction_out = trip_direction_select_r;

  // ---------------------------------------------------------------
  // Stabilisation interval
  // ---------------------------------------------------------------
  // Timer restarts on every enable; the reference must also report ready
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      settle_cnt_r <= '0;
      reference_stable_flag_r <= 1'b0;
    end else if (!detector_enable_r || (ctrl_wr && !reg_wdata[BIT_EN])) begin
      settle_cnt_r <= '0;
      reference_stable_flag_r <= 1'b0;
    end else if (settle_cnt_r < CNT_W'(STARTUP_COUNT)) begin
      settle_cnt_r <= settle_cnt_r + 1'b1;
      reference_stable_flag_r <= 1'b0;
    end else begin
      reference_stable_flag_r <= ready_s;
    end
  end

  // ---------------------------------------------------------------
  // Trip detection
  // ---------------------------------------------------------------
  // Comparator output is high when the monitored node is at or above trip
  assign trip_now = trip_direction_select_r ? comp_s : !comp_s;
  // Level sense: a standing condition keeps re-setting the flag
  assign trip_edge = trip_now;
  assign event_set = detector_enable_r && reference_stable_flag_r && trip_edge;

  // ---------------------------------------------------------------
  // Interrupt request, enable, priority and global bits
  // ---------------------------------------------------------------
  assign flag_clear = reg_write && (reg_addr == ADDR_IRQ_REQ2) && !reg_wdata[BIT_EVENT];
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      voltage_event_flag_r <= 1'b0;
    end else if (event_set) begin
      voltage_event_flag_r <= 1'b1;
    end else if (reg_write && (reg_addr == ADDR_IRQ_REQ2)) begin
      voltage_event_flag_r <= reg_wdata[BIT_EVENT];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      voltage_event_irq_enable_r <= 1'b0;
      voltage_event_priority_r <= 1'b0;
      global_irq_enable_r <= 1'b0;
    end else begin
      if (reg_write && (reg_addr == ADDR_IRQ_EN2)) begin
        voltage_event_irq_enable_r <= reg_wdata[BIT_EVENT];
      end
      if (reg_write && (reg_addr == ADDR_IRQ_PRI2)) begin
        voltage_event_priority_r <= reg_wdata[BIT_EVENT];
      end
      if (reg_write && (reg_addr == ADDR_INT_CTRL)) begin
        global_irq_enable_r <= reg_wdata[BIT_GIE];
      end
    end
  end

  // Vectoring needs global enable; waking from sleep does not
  assign irq_request = voltage_event_flag_r && voltage_event_irq_enable_r
                       && global_irq_enable_r;
  assign irq_priority = voltage_event_priority_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= in_sleep && (event_set || voltage_event_flag_r);
    end
  end
  assign wake_request = wake_r;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata_r <= BYTE_ZERO;
    end else if (reg_read) begin
      unique case (reg_addr)
        ADDR_CONTROL: reg_rdata_r <= {trip_direction_select_r, 1'b0,
                                      reference_stable_flag_r, detector_enable_r,
                                      trip_level_select_r};
        ADDR_IRQ_REQ2: reg_rdata_r <= {5'h00, voltage_event_flag_r, 2'h0};
        ADDR_IRQ_EN2: reg_rdata_r <= {5'h00, voltage_event_irq_enable_r, 2'h0};
        ADDR_IRQ_PRI2: reg_rdata_r <= {5'h00, voltage_event_priority_r, 2'h0};
        ADDR_INT_CTRL: reg_rdata_r <= {global_irq_enable_r, 7'h00};
        default: reg_rdata_r <= BYTE_ZERO;
      endcase
    end else begin
      reg_rdata_r <= BYTE_ZERO;
    end
  end
  assign reg_rdata = reg_rdata_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  flag_needs_stable_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(voltage_event_flag_r) |-> $past(reference_stable_flag_r))
    else $error("event flag rose without stable reference");
  flag_sets_a: assert property (@(posedge clock) disable iff (!reset_n)
    event_set |=> voltage_event_flag_r)
    else $error("trip did not set event flag");
  flag_holds_a: assert property (@(posedge clock) disable iff (!reset_n)
    voltage_event_flag_r && !flag_clear |=> voltage_event_flag_r)
    else $error("event flag dropped without clear");
  irq_gating_a: assert property (@(posedge clock) disable iff (!reset_n)
    irq_request == (voltage_event_flag_r && voltage_event_irq_enable_r
                    && global_irq_enable_r))
    else $error("interrupt request gating wrong");
  stable_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    !detector_enable_r |=> !reference_stable_flag_r)
    else $error("stable set while disabled");
  settle_restart_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(detector_enable_r) |-> !reference_stable_flag_r [*8])
    else $error("stable rose before settling");
  bit6_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    $past(reg_read) && $past(reg_addr) == ADDR_CONTROL |-> !reg_rdata[6])
    else $error("control bit 6 read nonzero");
  ext_select_a: assert property (@(posedge clock) disable iff (!reset_n)
    external_select == (tap_select == LEVEL_EXTERNAL))
    else $error("external select mismatch");
  dir_low_a: assert property (@(posedge clock) disable iff (!reset_n)
    event_set && !trip_direction_select_r |-> !comp_s)
    else $error("low event with comparator high");
  wake_sleep_a: assert property (@(posedge clock) disable iff (!reset_n)
    in_sleep && event_set |=> wake_request)
    else $error("no wake on sleep event");
  reset_ctrl_a: assert property (@(posedge clock)
    !reset_n |=> !detector_enable_r && trip_level_select_r == LEVEL_RESET)
    else $error("control not reset");
  stable_needs_ready_a: assert property (@(posedge clock) disable iff (!reset_n)
    reference_stable_flag_r |-> $past(ready_s))
    else $error("stable set without synced ready");
  event_needs_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(voltage_event_flag_r) && !$past(reg_write) |-> $past(detector_enable_r))
    else $error("event flag rose while disabled");
  dir_high_a: assert property (@(posedge clock) disable iff (!reset_n)
    event_set && trip_direction_select_r |-> comp_s)
    else $error("high event with comparator low");
  rdata_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    !$past(reg_read) |-> reg_rdata == BYTE_ZERO)
    else $error("read data not zero when idle");
  level_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    ctrl_wr |=> tap_select == $past(reg_wdata[3:0]))
    else $error("level field write lost");
endmodule // svd_detector

/* File: tb/svd_analog_model.sv */
/*
  Behavioural comparator and reference facing the voltage event detector.
  Assumes the detector drives power, tap and external select as levels.
*/
module svd_analog_model #(
  parameter int SETTLE_NS = 100
) (
  // Controls from the detector, and the external trip input
  input wire logic analog_power_en,
  input wire logic [3:0] tap_select,
  input wire logic external_select,
  input wire logic external_trip_input,
  // Stimulus
  input wire logic [3:0] supply_level,
  // Analog results
  output logic comp_above,
  output logic ref_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Comparator, dead while unpowered
  // ---------------------------------------------------------------
  assign comp_above = analog_power_en &&
    (external_select ? external_trip_input : (supply_level >= tap_select));
  // ---------------------------------------------------------------
  // Reference settles in real time, not in clocks
  // ---------------------------------------------------------------
  initial begin
    ref_ready = 1'b0;
    forever begin
      wait (analog_power_en);
      #(SETTLE_NS);
      ref_ready = analog_power_en;
      wait (!analog_power_en);
      ref_ready = 1'b0;
    end
  end
endmodule // svd_analog_model

/* File: tb/svd_detector_tb.sv */
/*
  Self-checking bench for the voltage event detector.
  Assumes the analog model beside it and a short start-up count.
*/
module svd_detector_tb;
  import svd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int START = 16;
  logic clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [3:0] reg_addr = 4'h0, supply = 4'hf, tap;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic comp_above, ref_ready, ext_in = 1'b0, in_sleep = 1'b0, dir, rd_q = 1'b0;
  logic analog_power_en, external_select, trip_direction_out;
  logic irq_request, irq_priority, wake_request;
  logic [3:0] tap_select;
  logic [7:0] exp_q[$];
  int bad_count = 0, n_tests = 0;
  always #4 clock = ~clock;
  svd_detector #(.STARTUP_COUNT(START)) svd_detector_inst (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .comp_above(comp_above), .ref_ready(ref_ready),
    .external_trip_input(ext_in), .analog_power_en(analog_power_en),
    .tap_select(tap_select), .external_select(external_select),
    .trip_direction_out(trip_direction_out), .in_sleep(in_sleep),
    .irq_request(irq_request), .irq_priority(irq_priority), .wake_request(wake_request));
  svd_analog_model svd_analog_model_inst (.analog_power_en(analog_power_en),
    .tap_select(tap_select), .external_select(external_select),
    .external_trip_input(ext_in), .supply_level(supply),
    .comp_above(comp_above), .ref_ready(ref_ready));
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    rd_q <= reg_read;
    if (rd_q && exp_q.size() > 0) check("reg_rdata", exp_q.pop_front(), reg_rdata);
  end
  initial begin
    #40000;
    bad_count++;
    print_verdict();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hdef4));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd(ADDR_CONTROL, 8'h05);
    rd(ADDR_IRQ_REQ2, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    wr(ADDR_CONTROL, 8'hff);
    rd(ADDR_CONTROL, 8'h9f);
    repeat (40) @(posedge clock);
    rd(ADDR_CONTROL, 8'hbf);
    wr(ADDR_IRQ_REQ2, 8'h00);
    rd(ADDR_IRQ_REQ2, 8'h00);
    ext_in <= 1'b1;
    repeat (6) @(posedge clock);
    rd(ADDR_IRQ_REQ2, 8'h04);
    ext_in <= 1'b0;
    // Random internal taps, both directions; ties with the tap are avoided
    for (int i = 0; i < 6; i++) begin
      tap = 4'($urandom_range(13, 1));
      dir = 1'($urandom_range(1, 0));
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, {4'h0, tap});
      wr(ADDR_CONTROL, {dir, 3'h0, tap});
      supply <= dir ? tap + 4'h1 : tap - 4'h1;
      wr(ADDR_CONTROL, {dir, 3'h1, tap});
      wr(ADDR_IRQ_REQ2, 8'h00);
      rd(ADDR_IRQ_REQ2, 8'h00);
      @(negedge clock);
      check("tap_select", {4'h0, tap}, {4'h0, tap_select});
      repeat (40) @(posedge clock);
      rd(ADDR_CONTROL, {dir, 3'h3, tap});
      rd(ADDR_IRQ_REQ2, 8'h04);
      supply <= dir ? tap - 4'h1 : tap + 4'h1;
      repeat (6) @(posedge clock);
      rd(ADDR_IRQ_REQ2, 8'h04);
      wr(ADDR_IRQ_REQ2, 8'h00);
      rd(ADDR_IRQ_REQ2, 8'h00);
    end
    // Flag held by a standing trip; every enable combination
    supply <= dir ? tap + 4'h1 : tap - 4'h1;
    repeat (6) @(posedge clock);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_IRQ_EN2, {5'h0, k[0], 2'h0});
      wr(ADDR_INT_CTRL, {k[1], 7'h0});
      @(negedge clock);
      check("irq_request", {7'h0, k == 3}, {7'h0, irq_request});
    end
    supply <= dir ? tap - 4'h1 : tap + 4'h1;
    // Let the synchroniser drain, else a late set beats the clear
    repeat (6) @(posedge clock);
    wr(ADDR_IRQ_REQ2, 8'h00);
    @(negedge clock);
    check("irq_request", 8'h00, {7'h0, irq_request});
    @(posedge clock);
    in_sleep <= 1'b1;
    supply <= dir ? tap + 4'h1 : tap - 4'h1;
    repeat (6) @(negedge clock);
    check("wake_request", 8'h01, {7'h0, wake_request});
    @(posedge clock);
    in_sleep <= 1'b0;
    wr(ADDR_CONTROL, {dir, 3'h0, tap});
    wr(ADDR_IRQ_REQ2, 8'h00);
    repeat (6) @(posedge clock);
    rd(ADDR_IRQ_REQ2, 8'h00);
    rd(ADDR_CONTROL, {dir, 3'h0, tap});
    repeat (3) @(posedge clock);
    print_verdict();
  end
endmodule // svd_detector_tb
